// File: logic/gop_defines.svh
// constants for the general output pin select block
`ifndef GOP_DEFINES_SVH
`define GOP_DEFINES_SVH

// selection field position inside an eight-bit pin configuration value
`define GOP_SEL_MSB      5
`define GOP_SEL_LSB      0

// selection codes
`define GOP_SEL_TX_THR   6'h02
`define GOP_SEL_HIZ      6'h2E
`define GOP_SEL_CLK_192  6'h3F

// whole-register value that routes the temperature sensor to pin a
`define GOP_TEMP_CFG     8'h80

// reset values of the two pin configuration registers
`define GOP_PIN_A_RST    8'h3F
`define GOP_PIN_B_RST    8'h2E

// crystal clock divider: full ratio and length of the high phase
`define GOP_DIV_RATIO    8'hC0
`define GOP_DIV_HALF     8'h60

`endif

// File: logic/gop_pkg.sv
// types shared by the general output pin select block
package gop_pkg;
  typedef logic [7:0] gop_cfg_t;
  typedef logic [5:0] gop_sel_t;
  typedef logic [6:0] gop_fill_t;
  // what pin b is doing at the moment
  typedef enum logic [1:0] {
    GOP_B_HIZ,
    GOP_B_SERIAL,
    GOP_B_FUNC
  } gop_b_mode_e;
endpackage

// File: logic/gop_clk_if.sv
// divided crystal clock carried from the divider to the pin selector
`timescale 1ns/1ps
interface gop_clk_if;
  logic clk_level;
  logic fall;
  modport src (output clk_level, output fall);
  modport snk (input clk_level, input fall);
endinterface

// File: logic/gop_clk_div.sv
// divide-by-192 crystal clock generator with a falling-boundary pulse
`timescale 1ns/1ps
`include "gop_defines.svh"
module gop_clk_div
  import gop_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  gop_clk_if.src    div_bus
);

  logic [7:0] cnt_ff;

  // runs from reset
  // free-running count; nothing can stop it, so a pin that selects code 3F gets a clock, except pin b while chip select is low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff == `GOP_DIV_RATIO - 8'h01) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // high for the first half, low for the second
  assign div_bus.clk_level = (cnt_ff < `GOP_DIV_HALF);
  // last high cycle: the level goes low at the next edge
  assign div_bus.fall      = (cnt_ff == `GOP_DIV_HALF - 8'h01);

  property p_div_period;
    @(posedge i_clk) disable iff (!i_rst_b)
      div_bus.fall |-> ##192 div_bus.fall;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider period is not 192");

  property p_div_low_after_fall;
    @(posedge i_clk) disable iff (!i_rst_b)
      div_bus.fall |=> !div_bus.clk_level ##95 !div_bus.clk_level ##1 div_bus.clk_level;
  endproperty
  a_div_low_after_fall: assert property (p_div_low_after_fall) else $error("low phase not 96");

endmodule

// File: logic/gop_top.sv
// general output pin select: chooses what drives output pins a and b
`timescale 1ns/1ps
`include "gop_defines.svh"
module gop_top
  import gop_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst_b,
  input  wire gop_cfg_t  i_pin_a_config_reg,
  input  wire gop_cfg_t  i_pin_b_config_reg,
  input  wire logic      i_cs_b,
  input  wire logic      i_serial_so_data,
  input  wire logic      i_serial_so_oe,
  input  wire gop_fill_t i_tx_fill_level,
  input  wire gop_fill_t i_tx_fill_threshold,
  output logic           o_general_out_a,
  output logic           o_general_out_a_oe,
  output logic           o_temp_sensor_en,
  output logic           o_general_out_b,
  output logic           o_general_out_b_oe
);

  gop_clk_if div_bus ();

  logic        cs_meta_ff;
  logic        cs_sync_ff;
  gop_cfg_t    a_cfg_ff;
  gop_cfg_t    b_cfg_ff;
  logic        thr_ff;
  gop_b_mode_e b_mode_ff;
  gop_b_mode_e nxt_b_mode;
  logic        a_temp;

  // select decode
  // one decoder serves both pins; unlisted codes fall to a quiet low level
  function automatic logic gop_decode(input gop_sel_t sel,
                                      input logic     clk_lv,
                                      input logic     thr);
    logic res;
    res = 1'b0;
    case (sel)
      `GOP_SEL_TX_THR:  res = thr;
      `GOP_SEL_CLK_192: res = clk_lv;
      default:          res = 1'b0;
    endcase
    return res;
  endfunction

  gop_clk_div u_div (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .div_bus (div_bus)
  );

  // chip select comes from a pin: two flops before anything reads it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
    end else begin
      cs_meta_ff <= i_cs_b;
      cs_sync_ff <= cs_meta_ff;
    end
  end

  // switch at fall
  // new selections take effect only as the divided clock goes low, so an
  // outgoing clock always finishes its high phase and an incoming one starts
  // with a whole low phase; the cost is up to 192 cycles of switch latency
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_cfg_ff <= `GOP_PIN_A_RST;
      b_cfg_ff <= `GOP_PIN_B_RST;
    end else if (div_bus.fall) begin
      a_cfg_ff <= i_pin_a_config_reg;
      b_cfg_ff <= i_pin_b_config_reg;
    end
  end

  // threshold with hold
  // equal fill holds the last state, giving one step of hysteresis
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      thr_ff <= 1'b0;
    end else if (i_tx_fill_level > i_tx_fill_threshold) begin
      thr_ff <= 1'b1;
    end else if (i_tx_fill_level < i_tx_fill_threshold) begin
      thr_ff <= 1'b0;
    end
  end

  assign a_temp = (a_cfg_ff == `GOP_TEMP_CFG);

  // pin a: digital driver off while the analog sensor owns the pad
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_general_out_a    <= 1'b0;
      o_general_out_a_oe <= 1'b1;
      o_temp_sensor_en   <= 1'b0;
    end else begin
      o_general_out_a    <= a_temp ? 1'b0 : gop_decode(a_cfg_ff[`GOP_SEL_MSB:`GOP_SEL_LSB],
                                                        div_bus.clk_level, thr_ff);
      o_general_out_a_oe <= !a_temp;
      o_temp_sensor_en   <= a_temp;
    end
  end

  // serial owns pin b
  // pin b mode: serial data while selected, else the programmed function
  always_comb begin
    nxt_b_mode = GOP_B_FUNC;
    if (!cs_sync_ff) begin
      nxt_b_mode = GOP_B_SERIAL;
    end else if (b_cfg_ff[`GOP_SEL_MSB:`GOP_SEL_LSB] == `GOP_SEL_HIZ) begin
      nxt_b_mode = GOP_B_HIZ;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      b_mode_ff <= GOP_B_HIZ;
    end else begin
      b_mode_ff <= nxt_b_mode;
    end
  end

  // pin b driver
  // pin b output and enable follow the mode chosen in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_general_out_b    <= 1'b0;
      o_general_out_b_oe <= 1'b0;
    end else begin
      case (nxt_b_mode)
        GOP_B_SERIAL: begin
          o_general_out_b    <= i_serial_so_data;
          o_general_out_b_oe <= i_serial_so_oe;
        end
        GOP_B_FUNC: begin
          o_general_out_b    <= gop_decode(b_cfg_ff[`GOP_SEL_MSB:`GOP_SEL_LSB],
                                           div_bus.clk_level, thr_ff);
          o_general_out_b_oe <= 1'b1;
        end
        default: begin
          o_general_out_b    <= 1'b0;
          o_general_out_b_oe <= 1'b0;
        end
      endcase
    end
  end

  // checks kept next to the logic they guard

  // fill above threshold under code 2, still selected one cycle later
  sequence s_thr_rise;
    (a_cfg_ff == {2'b00, `GOP_SEL_TX_THR}) && (i_tx_fill_level > i_tx_fill_threshold)
      ##1 (a_cfg_ff == {2'b00, `GOP_SEL_TX_THR});
  endsequence

  // fill below threshold under code 2, still selected one cycle later
  sequence s_thr_fall;
    (a_cfg_ff == {2'b00, `GOP_SEL_TX_THR}) && (i_tx_fill_level < i_tx_fill_threshold)
      ##1 (a_cfg_ff == {2'b00, `GOP_SEL_TX_THR});
  endsequence

  property p_thr_set;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_thr_rise |=> o_general_out_a;
  endproperty
  a_thr_set: assert property (p_thr_set) else $error("pin a not high above threshold");

  property p_thr_clr;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_thr_fall |=> !o_general_out_a;
  endproperty
  a_thr_clr: assert property (p_thr_clr) else $error("pin a not low below threshold");

  property p_a_clk;
    @(posedge i_clk) disable iff (!i_rst_b)
      (a_cfg_ff == `GOP_PIN_A_RST) |=> o_general_out_a == $past(div_bus.clk_level)
                                       && o_general_out_a_oe;
  endproperty
  a_a_clk: assert property (p_a_clk) else $error("pin a does not carry divided clock");

  property p_a_switch_at_fall;
    @(posedge i_clk) disable iff (!i_rst_b)
      $changed(a_cfg_ff) |-> $past(div_bus.fall);
  endproperty
  a_a_switch_at_fall: assert property (p_a_switch_at_fall) else $error("pin a switched mid phase");

  property p_temp;
    @(posedge i_clk) disable iff (!i_rst_b)
      a_temp |=> o_temp_sensor_en && !o_general_out_a_oe && !o_general_out_a;
  endproperty
  a_temp_route: assert property (p_temp) else $error("temperature sensor not routed");

  property p_reserved_low;
    @(posedge i_clk) disable iff (!i_rst_b)
      !a_temp && (a_cfg_ff[`GOP_SEL_MSB:`GOP_SEL_LSB] != `GOP_SEL_TX_THR)
        && (a_cfg_ff[`GOP_SEL_MSB:`GOP_SEL_LSB] != `GOP_SEL_CLK_192)
        |=> !o_general_out_a && o_general_out_a_oe;
  endproperty
  a_reserved_low: assert property (p_reserved_low) else $error("reserved code not low");

  property p_b_serial;
    @(posedge i_clk) disable iff (!i_rst_b)
      !cs_sync_ff |=> o_general_out_b == $past(i_serial_so_data)
                      && o_general_out_b_oe == $past(i_serial_so_oe);
  endproperty
  a_b_serial: assert property (p_b_serial) else $error("pin b lost serial data");

  property p_b_hiz;
    @(posedge i_clk) disable iff (!i_rst_b)
      cs_sync_ff && (b_cfg_ff[`GOP_SEL_MSB:`GOP_SEL_LSB] == `GOP_SEL_HIZ)
        |=> !o_general_out_b_oe;
  endproperty
  a_b_hiz: assert property (p_b_hiz) else $error("pin b driven while parked");

  property p_cs_latency;
    @(posedge i_clk) disable iff (!i_rst_b)
      $fell(i_cs_b) ##1 !i_cs_b ##1 !i_cs_b |=> b_mode_ff == GOP_B_SERIAL;
  endproperty
  a_cs_latency: assert property (p_cs_latency) else $error("chip select not honoured");

endmodule

// File: sim/gop_host_model.sv
// host model: watches pin a like an interrupt input and a clock input, and models the pin b line
`timescale 1ns/1ps
module gop_host_model (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_watch,
  input  wire logic i_pin_a,
  input  wire logic i_pin_b,
  input  wire logic i_pin_b_oe,
  output logic      o_short,
  output logic      o_pin_b_wire
);
  logic       last_a_ff;
  logic       last_b_ff;
  logic [8:0] run_ff;
  // both edges seen; clock runs shorter than a half period flagged
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_a_ff <= 1'b0;
      run_ff    <= 9'h000;
      o_short   <= 1'b0;
    end else if (i_pin_a !== last_a_ff) begin
      if (i_watch && run_ff < 9'h060) o_short <= 1'b1;
      last_a_ff <= i_pin_a;
      run_ff    <= 9'h001;
    end else if (run_ff != 9'h1FF) begin
      run_ff <= run_ff + 9'h001;
    end
  end
  // released line has no pull, so it shows the inverse of the last level
  always_ff @(posedge i_clk) begin
    if (i_pin_b_oe) last_b_ff <= i_pin_b;
  end
  assign o_pin_b_wire = i_pin_b_oe ? i_pin_b : ~last_b_ff;
endmodule

// File: sim/general_output_pin_select_tb.sv
// self-checking bench for the general output pin select block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module general_output_pin_select_tb;
  import gop_pkg::*;
  logic      i_clk = 1'b0;
  logic      i_rst_b = 1'b0;
  gop_cfg_t  cfg_a = 8'h3F;
  gop_cfg_t  cfg_b = 8'h2E;
  logic      cs_b = 1'b1;
  logic      so_data = 1'b0;
  logic      so_oe = 1'b0;
  gop_fill_t lvl = 7'h00;
  gop_fill_t thr = 7'h0A;
  logic      out_a, oe_a, temp_en, out_b, oe_b, watch = 1'b0, short, wire_b;
  int        error_cnt = 0;
  int        num_checks = 0;
  int        n;
  always #5 i_clk = ~i_clk;
  gop_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pin_a_config_reg(cfg_a),
    .i_pin_b_config_reg(cfg_b), .i_cs_b(cs_b), .i_serial_so_data(so_data),
    .i_serial_so_oe(so_oe), .i_tx_fill_level(lvl), .i_tx_fill_threshold(thr),
    .o_general_out_a(out_a), .o_general_out_a_oe(oe_a), .o_temp_sensor_en(temp_en),
    .o_general_out_b(out_b), .o_general_out_b_oe(oe_b));
  gop_host_model host (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_watch(watch),
    .i_pin_a(out_a), .i_pin_b(out_b), .i_pin_b_oe(oe_b), .o_short(short),
    .o_pin_b_wire(wire_b));
  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  // bounded wait for pin a to reach a level
  task automatic wait_a(input logic v);
    n = 0;
    while (out_a !== v && n < 400) begin
      cyc(1);
      n++;
    end
    if (out_a !== v) begin
      error_cnt++;
      final_report();
    end
  endtask
  // length of the current run of pin a at level v
  task automatic run_len(input logic v);
    wait_a(v);
    n = 0;
    while (out_a === v && n < 300) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_reset;
    `CHK(oe_b, 1'b0)
    `CHK(temp_en, 1'b0)
    // divided clock, running straight from reset
    wait_a(1'b0);
    run_len(1'b1);
    `CHK(n, 96)
    run_len(1'b0);
    `CHK(n, 96)
    $display("t_reset done");
  endtask
  task automatic t_thr;
    cfg_a = 8'h02;
    lvl = 7'h14;
    cyc(200);
    `CHK(out_a, 1'b1)
    `CHK(oe_a, 1'b1)
    lvl = 7'h0A;
    cyc(5);
    `CHK(out_a, 1'b1)
    lvl = 7'h05;
    cyc(3);
    `CHK(out_a, 1'b0)
    cfg_a = 8'h05;
    lvl = 7'h14;
    cyc(200);
    `CHK(out_a, 1'b0)
    $display("t_thr done");
  endtask
  task automatic t_temp;
    cfg_a = 8'h80;
    cyc(200);
    `CHK(temp_en, 1'b1)
    `CHK(oe_a, 1'b0)
    `CHK(out_a, 1'b0)
    cfg_a = 8'h3F;
    cyc(200);
    `CHK(temp_en, 1'b0)
    `CHK(oe_a, 1'b1)
    $display("t_temp done");
  endtask
  task automatic t_glitch;
    run_len(1'b1);
    watch = 1'b1;
    cyc(40);
    cfg_a = 8'h02;
    cyc(200);
    cfg_a = 8'h05;
    cyc(150);
    cfg_a = 8'h3F;
    cyc(250);
    run_len(1'b1);
    `CHK(n, 96)
    `CHK(short, 1'b0)
    watch = 1'b0;
    $display("t_glitch done");
  endtask
  task automatic t_pin_b;
    cs_b = 1'b0;
    so_oe = 1'b1;
    so_data = 1'b1;
    cyc(4);
    `CHK(oe_b, 1'b1)
    `CHK(wire_b, 1'b1)
    so_data = 1'b0;
    cyc(2);
    `CHK(wire_b, 1'b0)
    cfg_b = 8'h02;
    cyc(200);
    `CHK(wire_b, 1'b0)
    cs_b = 1'b1;
    so_oe = 1'b0;
    cyc(4);
    `CHK(out_b, 1'b1)
    `CHK(oe_b, 1'b1)
    cfg_b = 8'h05;
    cyc(200);
    `CHK(out_b, 1'b0)
    cfg_b = 8'h2E;
    cyc(200);
    `CHK(oe_b, 1'b0)
    $display("t_pin_b done");
  endtask
  initial begin
    cyc(2);
    i_rst_b = 1'b1;
    t_reset();
    t_thr();
    t_temp();
    t_glitch();
    t_pin_b();
    final_report();
  end
endmodule
